/* File: rtl/pcs_space.sv */
// configuration space end: 1024-word store with masked management writes
// assumes the user end holds its request until cs_access_done
// limitations:
//   status halves are never set here, so they always read zero
//   the attribute-fixed mask is empty until a core fixes bits
//   one access at a time; a write and a read never share a cycle
//   the user must drop both strobes for a cycle between accesses
`include "pcs_consts.svh"
module pcs_space
  import pcs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  pcs_if.dev        bus
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  // one word per configuration doubleword
  pcs_word_t  mem_q [`PCS_DEPTH];
  // sequencer and answer registers
  pcs_state_t st_q, st_d;
  pcs_word_t  rdata_q, rdata_d;
  logic       done_q, done_d;
  logic       take;
  // write path
  logic       wr_go;
  pcs_word_t  wr_word;
  pcs_word_t  cur_word;
  logic       stat_word;
  pcs_word_t  base_mask;
  pcs_word_t  rw_mask;
  pcs_word_t  bit_mask;
  // whole words behind the mirrors
  pcs_word_t  mirror_cmd, mirror_dev, mirror_dev2, mirror_lnk;

  // ----------------------------------------------------------------
  // word select and write mask
  // ----------------------------------------------------------------
  // the store is read combinationally, so a read costs no extra cycle
  assign cur_word = mem_q[bus.cs_word_index];

  // words whose upper half carries hardware status bits
  assign stat_word = (bus.cs_word_index == `PCS_IDX_CMDSTAT) ||
                     (bus.cs_word_index == `PCS_IDX_DEVCTL)  ||
                     (bus.cs_word_index == `PCS_IDX_LNKCTL);

  // normally writable bits per mirrored word; the rest is plain storage
  always_comb begin
    base_mask = `PCS_GEN_RW;
    unique case (bus.cs_word_index)
      `PCS_IDX_CMDSTAT: base_mask = `PCS_CMD_RW_MASK;
      `PCS_IDX_DEVCTL:  base_mask = `PCS_DEVCTL_RW;
      `PCS_IDX_DEVCTL2: base_mask = `PCS_DEVCTL2_RW;
      `PCS_IDX_LNKCTL:  base_mask = `PCS_LNKCTL_RW;
      default:          base_mask = `PCS_GEN_RW;
    endcase
  end

  // override opens every bit outside the attribute-fixed mask, reserved bits too;
  // attribute-fixed and status bits stay shut whatever the user asks, so software cannot forge them
  always_comb begin
    rw_mask = base_mask;
    if (bus.cs_override_ro) begin
      rw_mask = rw_mask | ~`PCS_IDENT_MASK;
    end
    if (stat_word) begin
      rw_mask = rw_mask & ~`PCS_STAT_KEEP;
    end
    rw_mask = rw_mask & ~`PCS_IDENT_MASK;
  end

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  // one slice per lane; a cleared mask bit keeps the stored byte
  for (genvar g = 0; g < `PCS_LANES; g++) begin : g_lane
    assign bit_mask[g*`PCS_LANE_W +: `PCS_LANE_W] =
      bus.cs_write_lane_mask[g] ? rw_mask[g*`PCS_LANE_W +: `PCS_LANE_W]
                                : '0;
  end

  // kept bits come from the store, opened bits from the user
  assign wr_word = (cur_word & ~bit_mask) |
                   (bus.cs_write_data & bit_mask);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // one access, in rising edges of sys_clk:
  //   edge 0   strobe seen high in idle; a write lands in the store,
  //            a read copies the selected word into the read register
  //   edge 1   done and fresh read data are sampled by the user end
  //   edge 2.. strobes still high belong to the same access
  //   first edge with both strobes low returns to idle
  // store write and done share edge 0, so a mirror never lags its done
  // held strobes after done are not a new access
  always_comb begin
    st_d = st_q;
    take = 1'b0;
    unique case (st_q)
      PCS_IDLE: begin
        if (bus.cs_write_strobe || bus.cs_read_strobe) begin
          take = 1'b1;
          st_d = PCS_DONE;
        end
      end
      PCS_BUSY: st_d = PCS_IDLE;
      // wait for both strobes to drop before the next access
      PCS_DONE: begin
        if (!bus.cs_write_strobe && !bus.cs_read_strobe) begin
          st_d = PCS_IDLE;
        end
      end
      default: st_d = PCS_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= PCS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  // write wins if both strobes are high, which the user must not do;
  // done is a one-cycle pulse for either kind of access
  always_comb begin
    rdata_d = rdata_q;
    done_d  = take;
    wr_go   = take && bus.cs_write_strobe;
    if (take && !bus.cs_write_strobe && bus.cs_read_strobe) begin
      rdata_d = cur_word;
    end
  end

  // answer registers; read data holds until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= `PCS_RESET_WORD;
      done_q  <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  // store cleared by reset so every mirror starts from a known zero;
  // costs a wide reset fan-out, traded for no separate init sequence
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < `PCS_DEPTH; i++) begin
        mem_q[i] <= `PCS_RESET_WORD;
      end
    end else if (wr_go) begin
      mem_q[bus.cs_word_index] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // continuous mirrors
  // ----------------------------------------------------------------
  // taps on fixed words; they follow the store with no added delay
  assign mirror_cmd  = mem_q[`PCS_IDX_CMDSTAT];
  assign mirror_dev  = mem_q[`PCS_IDX_DEVCTL];
  assign mirror_dev2 = mem_q[`PCS_IDX_DEVCTL2];
  assign mirror_lnk  = mem_q[`PCS_IDX_LNKCTL];

  // management answer, straight from its registers
  assign bus.cs_read_data        = rdata_q;
  assign bus.cs_access_done      = done_q;

  // header status is not carried; a constant keeps the port defined
  assign bus.hdr_status_mirror   = '0;

  // control halves sit low and status halves high in each word
  assign bus.hdr_command_mirror  = mirror_cmd[`PCS_CTL_HALF];
  assign bus.dev_status_mirror   = mirror_dev[`PCS_STAT_HALF];
  assign bus.dev_control_mirror  = mirror_dev[`PCS_CTL_HALF];
  assign bus.dev_control2_mirror = mirror_dev2[`PCS_CTL_HALF];
  assign bus.link_status_mirror  = mirror_lnk[`PCS_STAT_HALF];

endmodule // pcs_space

/* File: rtl/pcs_consts.svh */
// constants for the configuration space access port
// assumes inclusion by bare name from both ends and the interface
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_IDX_W        10
`define PCS_DEPTH        1024
`define PCS_DATA_W       32
`define PCS_LANES        4
`define PCS_HALF_W       16
`define PCS_LANE_W       8
// control half low, status half high in each mirrored word
`define PCS_CTL_HALF     15:0
`define PCS_STAT_HALF    31:16
// word indices of mirrored registers, plus the unmirrored device capabilities word
`define PCS_IDX_CMDSTAT  10'h001
`define PCS_IDX_DEVCAP   10'h01d
`define PCS_IDX_DEVCTL   10'h01e
`define PCS_IDX_LNKCTL   10'h020
`define PCS_IDX_DEVCTL2  10'h026
// per-word write masks: normal writable bits and extra override bits
`define PCS_CMD_RW_MASK  32'h0000_0547
`define PCS_DEVCTL_RW    32'h0000_7fff
`define PCS_DEVCTL2_RW   32'h0000_001f
`define PCS_LNKCTL_RW    32'h0000_01fb
`define PCS_GEN_RW       32'hffff_ffff
`define PCS_RO_EXTRA     32'h0000_0000
`define PCS_STAT_KEEP    32'hffff_0000
`define PCS_IDENT_MASK   32'h0000_0000
`define PCS_RESET_WORD   32'h0000_0000
`endif

/* File: rtl/pcs_pkg.sv */
// types for the configuration space access port
// assumes pcs_consts.svh is on the include path
`include "pcs_consts.svh"
package pcs_pkg;
  typedef logic [`PCS_IDX_W-1:0]  pcs_idx_t;
  typedef logic [`PCS_DATA_W-1:0] pcs_word_t;
  typedef logic [`PCS_LANES-1:0]  pcs_mask_t;
  typedef logic [`PCS_HALF_W-1:0] pcs_half_t;
  typedef enum logic [2:0] {
    PCS_IDLE = 3'b001,
    PCS_BUSY = 3'b010,
    PCS_DONE = 3'b100
  } pcs_state_t;
endpackage : pcs_pkg

/* File: rtl/pcs_if.sv */
// interface joining the user end and the configuration space end
// assumes one clock shared by both ends
`include "pcs_consts.svh"
interface pcs_if;
  import pcs_pkg::*;
  pcs_idx_t  cs_word_index;
  pcs_word_t cs_write_data;
  pcs_mask_t cs_write_lane_mask;
  logic      cs_write_strobe;
  logic      cs_read_strobe;
  logic      cs_override_ro;
  pcs_word_t cs_read_data;
  logic      cs_access_done;
  pcs_half_t hdr_status_mirror;
  pcs_half_t hdr_command_mirror;
  pcs_half_t dev_status_mirror;
  pcs_half_t dev_control_mirror;
  pcs_half_t dev_control2_mirror;
  pcs_half_t link_status_mirror;
  modport dev (
    input  cs_word_index, cs_write_data, cs_write_lane_mask,
    input  cs_write_strobe, cs_read_strobe, cs_override_ro,
    output cs_read_data, cs_access_done, hdr_status_mirror,
    output hdr_command_mirror, dev_status_mirror, dev_control_mirror,
    output dev_control2_mirror, link_status_mirror
  );
  modport usr (
    output cs_word_index, cs_write_data, cs_write_lane_mask,
    output cs_write_strobe, cs_read_strobe, cs_override_ro,
    input  cs_read_data, cs_access_done, hdr_status_mirror,
    input  hdr_command_mirror, dev_status_mirror, dev_control_mirror,
    input  dev_control2_mirror, link_status_mirror
  );
endinterface : pcs_if

/* File: rtl/pcs_user.sv */
// user end: turns one-cycle requests into held management accesses
// assumes the configuration space end on the same clock
`include "pcs_consts.svh"
module pcs_user
  import pcs_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      srst,
  input  wire logic      req_valid,
  input  wire logic      req_write,
  input  wire pcs_idx_t  req_index,
  input  wire pcs_word_t req_data,
  input  wire pcs_mask_t req_mask,
  input  wire logic      req_override,
  output logic           req_ready,
  output logic           rsp_valid,
  output pcs_word_t      rsp_data,
  pcs_if.usr             bus
);

  // ----------------------------------------------------------------
  // request holder
  // ----------------------------------------------------------------
  pcs_state_t st_q, st_d;
  logic       wr_q, wr_d;
  pcs_idx_t   idx_q, idx_d;
  pcs_word_t  dat_q, dat_d;
  pcs_mask_t  msk_q, msk_d;
  logic       ovr_q, ovr_d;
  logic       rv_q, rv_d;
  pcs_word_t  rd_q, rd_d;

  // fields held stable until done so the far end samples a clean request
  always_comb begin
    st_d  = st_q;
    wr_d  = wr_q;
    idx_d = idx_q;
    dat_d = dat_q;
    msk_d = msk_q;
    ovr_d = ovr_q;
    rv_d  = 1'b0;
    rd_d  = rd_q;
    unique case (st_q)
      PCS_IDLE: begin
        if (req_valid) begin
          wr_d  = req_write;
          idx_d = req_index;
          dat_d = req_data;
          msk_d = req_mask;
          ovr_d = req_override;
          st_d  = PCS_BUSY;
        end
      end
      PCS_BUSY: begin
        if (bus.cs_access_done) begin
          rv_d = 1'b1;
          if (!wr_q) begin
            rd_d = bus.cs_read_data;
          end
          st_d = PCS_DONE;
        end
      end
      PCS_DONE: st_d = PCS_IDLE; // strobes drop for one cycle
      default:  st_d = PCS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q  <= PCS_IDLE;
      wr_q  <= 1'b0;
      idx_q <= '0;
      dat_q <= '0;
      msk_q <= '0;
      ovr_q <= 1'b0;
      rv_q  <= 1'b0;
      rd_q  <= '0;
    end else begin
      st_q  <= st_d;
      wr_q  <= wr_d;
      idx_q <= idx_d;
      dat_q <= dat_d;
      msk_q <= msk_d;
      ovr_q <= ovr_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
    end
  end

  // strobes never both high; held through BUSY only
  assign bus.cs_write_strobe    = (st_q == PCS_BUSY) && wr_q;
  assign bus.cs_read_strobe     = (st_q == PCS_BUSY) && !wr_q;
  assign bus.cs_word_index      = idx_q;
  assign bus.cs_write_data      = dat_q;
  assign bus.cs_write_lane_mask = msk_q;
  assign bus.cs_override_ro     = ovr_q;
  assign req_ready              = (st_q == PCS_IDLE);
  assign rsp_valid              = rv_q;
  assign rsp_data               = rd_q;

endmodule // pcs_user

/* File: tb/pcs_chk.sv */
// checker for the configuration space access interface
// assumes one clock and a synchronous active-high reset
`include "pcs_consts.svh"
module pcs_chk
  import pcs_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      srst,
  input wire pcs_idx_t  cs_word_index,
  input wire logic      cs_write_strobe,
  input wire logic      cs_read_strobe,
  input wire pcs_word_t cs_read_data,
  input wire logic      cs_access_done,
  input wire pcs_half_t hdr_status_mirror,
  input wire pcs_half_t hdr_command_mirror,
  input wire pcs_half_t dev_status_mirror,
  input wire pcs_half_t dev_control_mirror,
  input wire pcs_half_t dev_control2_mirror,
  input wire pcs_half_t link_status_mirror
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // -------------------------------------------------------------
  // handshake
  // -------------------------------------------------------------
  logic strb;
  assign strb = cs_write_strobe | cs_read_strobe;
  // strobe up, held through done, then dropped
  sequence held_req_s;
    strb ##1 strb ##1 !strb;
  endsequence
  sequence done_pulse_s;
    cs_access_done ##1 !cs_access_done;
  endsequence
  done_one_cycle_a: assert property (
    $rose(strb) |=> done_pulse_s)
    else $error("done not one cycle after strobe");
  req_held_a: assert property ($rose(strb) |-> held_req_s)
    else $error("strobe not held until done");
  index_stable_a: assert property (strb && !cs_access_done |=>
    $stable(cs_word_index)) else $error("index moved in access");
  done_cause_a: assert property (cs_access_done |-> $past(strb) && strb)
    else $error("done without a request");
  one_strobe_a: assert property (!(cs_write_strobe && cs_read_strobe))
    else $error("both strobes high");
  // -------------------------------------------------------------
  // data and mirrors move only when an access completes
  // -------------------------------------------------------------
  rdata_hold_a: assert property ($changed(cs_read_data) |->
    cs_access_done && cs_read_strobe) else $error("read data moved");
  status_zero_a: assert property (hdr_status_mirror == 16'h0000)
    else $error("status mirror not zero");
  cmd_mirror_a: assert property ($changed(hdr_command_mirror) |->
    cs_access_done && cs_write_strobe) else $error("command mirror moved");
  // device mirrors move only with the write that changes their word
  logic [3*`PCS_HALF_W-1:0] dev_bits;
  assign dev_bits = {dev_control_mirror, dev_status_mirror,
                     dev_control2_mirror};
  dev_mirror_a: assert property ($changed(dev_bits) |->
    cs_access_done && cs_write_strobe) else $error("device mirror moved");
  lnk_mirror_a: assert property ($changed(link_status_mirror) |->
    cs_access_done && cs_write_strobe) else $error("link mirror moved");
endmodule // pcs_chk

/* File: tb/test_pcie_cfg_space_access.sv */
// self-checking bench: user end and space end joined by pcs_if
// assumes the rtl package and constants are compiled first
`include "pcs_consts.svh"
module test_pcie_cfg_space_access
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic      sys_clk, srst, req_valid, req_write, req_override;
  logic      req_ready, rsp_valid;
  pcs_idx_t  req_index;
  pcs_word_t req_data, rsp_data;
  pcs_mask_t req_mask;
  int        failures, checked;
  pcs_if bus ();
  pcs_space pcs_space_i (.sys_clk(sys_clk), .srst(srst), .bus(bus));
  pcs_user pcs_user_i (.sys_clk(sys_clk), .srst(srst),
    .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_data(req_data), .req_mask(req_mask),
    .req_override(req_override), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus));
  pcs_chk pcs_chk_i (.sys_clk(sys_clk), .srst(srst),
    .cs_word_index(bus.cs_word_index),
    .cs_write_strobe(bus.cs_write_strobe),
    .cs_read_strobe(bus.cs_read_strobe),
    .cs_read_data(bus.cs_read_data),
    .cs_access_done(bus.cs_access_done),
    .hdr_status_mirror(bus.hdr_status_mirror),
    .hdr_command_mirror(bus.hdr_command_mirror),
    .dev_status_mirror(bus.dev_status_mirror),
    .dev_control_mirror(bus.dev_control_mirror),
    .dev_control2_mirror(bus.dev_control2_mirror),
    .link_status_mirror(bus.link_status_mirror));
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input pcs_word_t got, input pcs_word_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_lat(input int got, input int exp);
    checked++;
    if (got != exp) begin
      failures++;
      $display("[ERR] %0t latency %0d expected %0d", $time, got, exp);
    end
  endtask
  // one access; bounded waits so a hang shows as a latency failure, not a stall
  task automatic acc(input logic w, input pcs_idx_t i, input pcs_word_t d,
                     input pcs_mask_t m, input logic o,
                     output pcs_word_t r);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    {req_valid, req_write, req_index} = {1'b1, w, i};
    {req_data, req_mask, req_override} = {d, m, o};
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    // rsp_valid shows two edges after the edge that took the request
    cmp_lat(n, 2);
    r = rsp_data;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  // both ends of the index range, back to back
  task automatic t_edges;
    pcs_word_t r;
    acc(1'b1, 10'h3ff, 32'ha5a5_5a5a, 4'hf, 1'b0, r);
    acc(1'b1, 10'h000, 32'h0123_4567, 4'hf, 1'b0, r);
    acc(1'b0, 10'h3ff, 32'h0, 4'h0, 1'b0, r);
    cmp(r, 32'ha5a5_5a5a);
    acc(1'b0, 10'h000, 32'h0, 4'h0, 1'b0, r);
    cmp(r, 32'h0123_4567);
  endtask
  // every lane mask on a plain word
  task automatic t_lanes;
    pcs_word_t r, e;
    for (int m = 0; m < 16; m++) begin
      acc(1'b1, 10'h100, 32'h0, 4'hf, 1'b0, r);
      acc(1'b1, 10'h100, 32'hffff_ffff, 4'(m), 1'b0, r);
      acc(1'b0, 10'h100, 32'h0, 4'h0, 1'b0, r);
      for (int b = 0; b < 4; b++) e[8*b +: 8] = m[b] ? 8'hff : 8'h00;
      cmp(r, e);
    end
  endtask
  // read-only override and status keep on mirrored words
  task automatic t_ro;
    pcs_idx_t  ix[5] = '{10'h001, 10'h001, 10'h01e, 10'h020, 10'h026};
    logic      ov[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    pcs_word_t ex[5] = '{32'h0000_0547, 32'h0000_ffff, 32'h0000_7fff,
                         32'h0000_ffff, 32'h0000_001f};
    pcs_word_t r;
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ix[k], 32'hffff_ffff, 4'hf, ov[k], r);
      acc(1'b0, ix[k], 32'h0, 4'h0, 1'b0, r);
      cmp(r, ex[k]);
    end
    cmp({16'h0, bus.hdr_command_mirror}, 32'h0000_ffff);
    cmp({16'h0, bus.dev_status_mirror}, 32'h0);
    cmp({16'h0, bus.dev_control_mirror}, 32'h0000_7fff);
    cmp({16'h0, bus.dev_control2_mirror}, 32'h0000_001f);
    cmp({16'h0, bus.link_status_mirror}, 32'h0);
    cmp({16'h0, bus.hdr_status_mirror}, 32'h0);
  endtask
  // mid-run reset clears the store, the command and device control mirrors and the read answer
  task automatic t_rst;
    pcs_word_t r;
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    cmp(rsp_data, 32'h0);
    cmp({16'h0, bus.hdr_command_mirror}, 32'h0);
    cmp({16'h0, bus.dev_control_mirror}, 32'h0);
    acc(1'b0, 10'h026, 32'h0, 4'h0, 1'b0, r);
    cmp(r, 32'h0);
  endtask
  // -------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {srst, req_valid, req_write, req_override} = 4'hf;
    {req_valid, req_write, req_override} = 3'h0;
    {req_index, req_data, req_mask} = '0;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    t_edges;
    t_lanes;
    t_ro;
    t_rst;
    end_sim;
  end
  // run needs about 263 cycles; over seven times that is a hang
  initial begin
    repeat (2000) @(posedge sys_clk);
    failures++;
    end_sim;
  end
endmodule // test_pcie_cfg_space_access
